// ---- pkg/clock_reset_params.svh ----
`ifndef CLOCK_RESET_PARAMS_SVH
`define CLOCK_RESET_PARAMS_SVH

// Period of the block clock in nanoseconds (125 MHz).
`define CLK_PERIOD_NS 8

// Extra hold of the system reset after every hardware reset source has gone away.
`define POR_STRETCH_NS 1000
`define POR_STRETCH_CYC ((`POR_STRETCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_CNT_W 8

// The 100 MHz source rate is made from the 125 MHz clock by a phase accumulator.
`define PLL_ACC_W 8
`define PLL_STEP 8'h64
`define PLL_WRAP 8'h7D

// Select pin codes.
`define SEL_25 2'h0
`define SEL_50 2'h1
`define SEL_RSVD 2'h2
`define SEL_100 2'h3

// Division of the 100 MHz source for each select code, and of the pin clock.
`define SEL_DIV_W 3
`define RATIO_25 3'h4
`define RATIO_50 3'h2
`define RATIO_100 3'h1
`define RATIO_PIN 3'h1

// Slow power mode division.
`define SLOW_DIV 100
`define SLOW_DIV_W 7

// Widths of checking counters.
`define GAP_W 8
`define SEL_HOLD_W 4
`define SEL_HOLD_MAX 4'hF

`endif

// ---- pkg/clock_reset_pkg.sv ----
`default_nettype none

package clock_reset_pkg;

    // Role of the local bus clock pin, fixed from the straps during reset.
    typedef enum logic [1:0] {
        ROLE_CLOCK_IN,
        ROLE_CLOCK_OUT,
        ROLE_UNUSED
    } lb_role_t;

    // Sequencing of the system reset.
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_STRETCH,
        ST_ALIGN,
        ST_RUN
    } rst_state_t;

endpackage

`default_nettype wire

// ---- core/rise_detect.sv ----
`timescale 1ns/100ps
`default_nettype none

module rise_detect #(
    parameter int WIDTH = 3
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Levels in and rising edges out.
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] rise
);

    generate
        if (WIDTH < 1) begin : g_bad
            $error("rise_detect needs at least one bit.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic prev_ff; // Last sampled level of this bit.

            // Reset to high so a level already high at release is not taken as an edge.
            always_ff @(posedge clk) begin
                if (rst) begin
                    prev_ff <= 1'b1;
                end else begin
                    prev_ff <= din[i];
                end
            end

            assign rise[i] = din[i] & ~prev_ff;
        end
    endgenerate

endmodule // rise_detect
`default_nettype wire

// ---- core/tick_divider.sv ----
`timescale 1ns/100ps
`default_nettype none

module tick_divider #(
    parameter int WIDTH = 3
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Source ticks and wanted ratio.
    input wire logic en_in,
    input wire logic [WIDTH-1:0] ratio,
    // Divided ticks and the ratio now in force.
    output logic tick,
    output logic [WIDTH-1:0] cur_ratio_ff
);

    generate
        if (WIDTH < 1) begin : g_bad
            $error("tick_divider needs at least one bit.");
        end
    endgenerate

    logic [WIDTH-1:0] cnt_ff; // Source ticks left before the next output tick.
    logic wrap; // Counter is at its last step.

    assign wrap = (cnt_ff == '0);
    assign tick = en_in & wrap;

    ////////////////////////////////////////////////////////////////////////////
    // A new ratio is taken only at a wrap, so no output period is ever cut short.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
            cur_ratio_ff <= WIDTH'(1);
        end else if (en_in) begin
            if (wrap) begin
                cur_ratio_ff <= ratio;
                cnt_ff <= ratio - WIDTH'(1);
            end else begin
                cnt_ff <= cnt_ff - WIDTH'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_ratio_at_wrap;
        @(posedge clk) disable iff (rst)
        $changed(cur_ratio_ff) |-> $past(tick);
    endproperty
    a_ratio_at_wrap: assert property (p_ratio_at_wrap)
        else $error("Divider ratio changed away from a wrap.");

endmodule // tick_divider
`default_nettype wire

// ---- core/clock_reset_generation.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "clock_reset_params.svh"

module clock_reset_generation #(
    parameter int POR_STRETCH_CYC = `POR_STRETCH_CYC,
    parameter int SLOW_DIV = `SLOW_DIV
) (
    // Clock and block reset.
    input wire logic clk,
    input wire logic rst,
    // Reset sources.
    input wire logic ext_reset_n_in,
    input wire logic core_supply_ok,
    // Clock selection and straps.
    input wire logic [1:0] core_clock_select_pins,
    input wire logic bus_role_strap,
    input wire logic timing_style_strap,
    // Local bus clock pin, split into its three signals.
    input wire logic local_bus_clock_pin_in,
    output logic local_bus_clock_pin_out_ff,
    output logic local_bus_clock_pin_oe_ff,
    // Power control.
    input wire logic slow_power_mode,
    input wire logic stop_mode_req,
    input wire logic remote_wakeup_in,
    output logic osc_enable_ff,
    output logic pll_enable_ff,
    output logic wakeup_event_ff,
    // System side.
    output logic sys_clk_en_ff,
    output logic system_reset_ff,
    output logic cpu_reset_indicator_out_ff,
    output var clock_reset_pkg::lb_role_t lb_role_ff
);

    localparam int PCW = `POR_CNT_W;
    localparam int SW = `SLOW_DIV_W;
    localparam int GW = `GAP_W;

    // Refuse settings that the counters cannot hold.
    generate
        if (POR_STRETCH_CYC < 1 || POR_STRETCH_CYC > (1 << PCW)) begin : g_bad_por
            $error("POR_STRETCH_CYC out of range.");
        end
        if (SLOW_DIV < 2 || SLOW_DIV >= (1 << SW)) begin : g_bad_slow
            $error("SLOW_DIV out of range.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Internal signals.
    clock_reset_pkg::rst_state_t state_ff; // Reset sequencer state.
    logic [PCW-1:0] por_cnt_ff; // Cycles spent in the stretch.
    logic [`PLL_ACC_W-1:0] pll_acc_ff; // Phase of the 100 MHz source.
    logic pll_tick; // One source period of 100 MHz has passed.
    logic [2:0] rises; // Edges of supply, wakeup and pin clock.
    logic supply_rise; // Core supply just became good.
    logic wake_rise; // Wakeup input rising edge.
    logic pin_rise; // Rising edge of the incoming pin clock.
    logic hw_rst; // Any hardware reset source is active.
    logic [`SEL_DIV_W-1:0] sel_ratio_ff; // Ratio from the last valid select code.
    logic [`SEL_DIV_W-1:0] fast_ratio; // Ratio handed to the first divider.
    logic src_tick; // Chosen source tick, gated by stop.
    logic fast_tick; // Full speed system tick.
    logic slow_tick; // Tick divided for slow power mode.
    logic slow_lat_ff; // Slow mode as currently applied.
    logic sys_tick; // System tick in force.
    logic [SW-1:0] slow_ratio; // Slow division handed to the second divider.

    assign supply_rise = rises[2];
    assign wake_rise = rises[1];
    assign pin_rise = rises[0];
    assign slow_ratio = SW'(SLOW_DIV);

    // Supply loss, supply rise and the external input all hold the system in reset.
    assign hw_rst = ~ext_reset_n_in | ~core_supply_ok | supply_rise;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the three slow inputs.
    rise_detect #(
        .WIDTH(3)
    ) u_rise (
        .clk(clk),
        .rst(rst),
        .din({core_supply_ok, remote_wakeup_in, local_bus_clock_pin_in}),
        .rise(rises)
    );

    ////////////////////////////////////////////////////////////////////////////
    // The 100 MHz source runs freely while the oscillator and PLL are on.
    // It stops dead when they are off, so nothing downstream sees a stray tick.
    always_ff @(posedge clk) begin
        if (rst || !pll_enable_ff) begin
            pll_acc_ff <= '0;
        end else if (pll_acc_ff >= (`PLL_WRAP - `PLL_STEP)) begin
            pll_acc_ff <= pll_acc_ff + `PLL_STEP - `PLL_WRAP;
        end else begin
            pll_acc_ff <= pll_acc_ff + `PLL_STEP;
        end
    end

    assign pll_tick = pll_enable_ff & (pll_acc_ff >= (`PLL_WRAP - `PLL_STEP));

    ////////////////////////////////////////////////////////////////////////////
    // Select decode; the reserved code keeps the ratio already chosen.
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_ratio_ff <= `RATIO_25;
        end else begin
            case (core_clock_select_pins)
                `SEL_25: begin
                    sel_ratio_ff <= `RATIO_25;
                end
                `SEL_50: begin
                    sel_ratio_ff <= `RATIO_50;
                end
                `SEL_100: begin
                    sel_ratio_ff <= `RATIO_100;
                end
                default: begin
                    sel_ratio_ff <= sel_ratio_ff;
                end
            endcase
        end
    end

    // With the pin as source its edges are the system clock as supplied.
    // Timer accuracy then depends on the outside party matching the select code.
    always_comb begin
        if (lb_role_ff == clock_reset_pkg::ROLE_CLOCK_IN) begin
            src_tick = pin_rise & osc_enable_ff;
            fast_ratio = `RATIO_PIN;
        end else begin
            src_tick = pll_tick;
            fast_ratio = sel_ratio_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // First divider gives the full speed tick, second the slow one.
    tick_divider #(
        .WIDTH(`SEL_DIV_W)
    ) u_fast_div (
        .clk(clk),
        .rst(rst),
        .en_in(src_tick),
        .ratio(fast_ratio),
        .tick(fast_tick),
        .cur_ratio_ff()
    );

    tick_divider #(
        .WIDTH(SW)
    ) u_slow_div (
        .clk(clk),
        .rst(rst),
        .en_in(fast_tick),
        .ratio(slow_ratio),
        .tick(slow_tick),
        .cur_ratio_ff()
    );

    // In the run state slow mode is entered and left only at a slow wrap, so no period is clipped.
    // The cost is up to one slow period of delay before the change shows.
    always_ff @(posedge clk) begin
        if (rst) begin
            slow_lat_ff <= 1'b0;
        end else if (state_ff != clock_reset_pkg::ST_RUN || slow_tick) begin
            slow_lat_ff <= slow_power_mode;
        end
    end

    assign sys_tick = slow_lat_ff ? slow_tick : fast_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Stop mode: oscillator and PLL go off; a wakeup edge or any reset restarts them.
    always_ff @(posedge clk) begin
        if (rst || hw_rst || wake_rise) begin
            osc_enable_ff <= 1'b1;
            pll_enable_ff <= 1'b1;
        end else if (stop_mode_req && state_ff == clock_reset_pkg::ST_RUN) begin
            osc_enable_ff <= 1'b0;
            pll_enable_ff <= 1'b0;
        end
    end

    // Wakeup edges are reported whether or not the block is stopped.
    always_ff @(posedge clk) begin
        if (rst) begin
            wakeup_event_ff <= 1'b0;
        end else begin
            wakeup_event_ff <= wake_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer: hold, stretch, then wait for a system tick to release.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= clock_reset_pkg::ST_HOLD;
        end else begin
            case (state_ff)
                clock_reset_pkg::ST_HOLD: begin
                    if (!hw_rst) begin
                        state_ff <= clock_reset_pkg::ST_STRETCH;
                    end
                end
                clock_reset_pkg::ST_STRETCH: begin
                    if (hw_rst) begin
                        state_ff <= clock_reset_pkg::ST_HOLD;
                    end else if (por_cnt_ff == PCW'(POR_STRETCH_CYC - 1)) begin
                        state_ff <= clock_reset_pkg::ST_ALIGN;
                    end
                end
                clock_reset_pkg::ST_ALIGN: begin
                    if (hw_rst) begin
                        state_ff <= clock_reset_pkg::ST_HOLD;
                    end else if (sys_tick) begin
                        state_ff <= clock_reset_pkg::ST_RUN;
                    end
                end
                clock_reset_pkg::ST_RUN: begin
                    if (hw_rst) begin
                        state_ff <= clock_reset_pkg::ST_HOLD;
                    end
                end
                default: begin
                    state_ff <= clock_reset_pkg::ST_HOLD;
                end
            endcase
        end
    end

    // Stretch counter runs only in the stretch state.
    always_ff @(posedge clk) begin
        if (rst || state_ff != clock_reset_pkg::ST_STRETCH) begin
            por_cnt_ff <= '0;
        end else begin
            por_cnt_ff <= por_cnt_ff + PCW'(1);
        end
    end

    // Straps are followed throughout the hold and frozen once it ends.
    // Both straps low is not a documented combination and leaves the pin idle.
    always_ff @(posedge clk) begin
        if (rst) begin
            lb_role_ff <= clock_reset_pkg::ROLE_UNUSED;
        end else if (state_ff == clock_reset_pkg::ST_HOLD) begin
            if (bus_role_strap && timing_style_strap) begin
                lb_role_ff <= clock_reset_pkg::ROLE_CLOCK_IN;
            end else if (!bus_role_strap && timing_style_strap) begin
                lb_role_ff <= clock_reset_pkg::ROLE_CLOCK_OUT;
            end else begin
                lb_role_ff <= clock_reset_pkg::ROLE_UNUSED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System reset falls in the same edge that enters the run state.
    always_ff @(posedge clk) begin
        if (rst) begin
            system_reset_ff <= 1'b1;
        end else if (hw_rst) begin
            system_reset_ff <= 1'b1;
        end else if (state_ff == clock_reset_pkg::ST_ALIGN && sys_tick) begin
            system_reset_ff <= 1'b0;
        end else if (state_ff != clock_reset_pkg::ST_RUN) begin
            system_reset_ff <= 1'b1;
        end
    end

    // The indicator is the inverse of the CPU's reset, one cycle later.
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_reset_indicator_out_ff <= 1'b0;
        end else begin
            cpu_reset_indicator_out_ff <= ~system_reset_ff;
        end
    end

    // System tick and the pin clock output.
    always_ff @(posedge clk) begin
        if (rst) begin
            sys_clk_en_ff <= 1'b0;
            local_bus_clock_pin_out_ff <= 1'b0;
            local_bus_clock_pin_oe_ff <= 1'b0;
        end else begin
            sys_clk_en_ff <= sys_tick;
            local_bus_clock_pin_out_ff <= sys_tick & (lb_role_ff == clock_reset_pkg::ROLE_CLOCK_OUT);
            local_bus_clock_pin_oe_ff <= (lb_role_ff == clock_reset_pkg::ROLE_CLOCK_OUT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper counters read only by the checks below.
    logic [GW-1:0] gap_cnt_ff; // Cycles since the last system tick.
    logic gap_valid_ff; // Last tick was already a slow one.
    logic [`SEL_HOLD_W-1:0] sel_hold_ff; // Cycles the select pins stayed put.

    always_ff @(posedge clk) begin
        if (rst) begin
            gap_cnt_ff <= '0;
            gap_valid_ff <= 1'b0;
        end else if (sys_tick) begin
            gap_cnt_ff <= '0;
            gap_valid_ff <= slow_lat_ff;
        end else if (gap_cnt_ff != '1) begin
            gap_cnt_ff <= gap_cnt_ff + GW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst || core_clock_select_pins != $past(core_clock_select_pins)) begin
            sel_hold_ff <= '0;
        end else if (sel_hold_ff != `SEL_HOLD_MAX) begin
            sel_hold_ff <= sel_hold_ff + `SEL_HOLD_W'(1);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_ext_low;
        !ext_reset_n_in;
    endsequence

    sequence s_in_reset_then_run;
        system_reset_ff ##1 !system_reset_ff;
    endsequence

    property p_full_speed;
        (sel_hold_ff == `SEL_HOLD_MAX && core_clock_select_pins == `SEL_100 && pll_tick
         && !slow_lat_ff && lb_role_ff != clock_reset_pkg::ROLE_CLOCK_IN) |=> sys_clk_en_ff;
    endproperty
    a_full_speed: assert property (p_full_speed)
        else $error("Full speed select did not tick on every source tick.");

    property p_strap_frozen;
        (state_ff != clock_reset_pkg::ST_HOLD && $past(state_ff) != clock_reset_pkg::ST_HOLD)
        |-> $stable(lb_role_ff);
    endproperty
    a_strap_frozen: assert property (p_strap_frozen)
        else $error("Pin role changed outside the reset hold.");

    property p_pin_source;
        (state_ff == clock_reset_pkg::ST_RUN && lb_role_ff == clock_reset_pkg::ROLE_CLOCK_IN
         && pin_rise && osc_enable_ff && !slow_lat_ff) |=> sys_clk_en_ff;
    endproperty
    a_pin_source: assert property (p_pin_source)
        else $error("Pin clock edge did not produce a system tick.");

    property p_drive_out;
        (lb_role_ff == clock_reset_pkg::ROLE_CLOCK_OUT) |=> local_bus_clock_pin_oe_ff;
    endproperty
    a_drive_out: assert property (p_drive_out)
        else $error("Clock output role without drive.");

    property p_unused_pin;
        (lb_role_ff != clock_reset_pkg::ROLE_CLOCK_OUT) |=> !local_bus_clock_pin_oe_ff && !local_bus_clock_pin_out_ff;
    endproperty
    a_unused_pin: assert property (p_unused_pin)
        else $error("Pin driven while not in clock output role.");

    property p_stop;
        (stop_mode_req && state_ff == clock_reset_pkg::ST_RUN && !hw_rst && !wake_rise)
        |=> !osc_enable_ff && !pll_enable_ff ##1 !sys_clk_en_ff;
    endproperty
    a_stop: assert property (p_stop)
        else $error("Stop request left oscillator or ticks running.");

    property p_slow_gap;
        (sys_tick && slow_lat_ff && gap_valid_ff) |-> gap_cnt_ff >= GW'(SLOW_DIV - 1);
    endproperty
    a_slow_gap: assert property (p_slow_gap)
        else $error("Slow mode ticks closer than the division allows.");

    property p_ext_reset;
        s_ext_low |=> system_reset_ff ##1 !cpu_reset_indicator_out_ff;
    endproperty
    a_ext_reset: assert property (p_ext_reset)
        else $error("External reset did not reach system reset and indicator.");

    property p_indicator;
        s_in_reset_then_run |=> cpu_reset_indicator_out_ff;
    endproperty
    a_indicator: assert property (p_indicator)
        else $error("Indicator did not rise after reset release.");

    property p_wakeup;
        $rose(remote_wakeup_in) && !$past(rst) |=> wakeup_event_ff && osc_enable_ff;
    endproperty
    a_wakeup: assert property (p_wakeup)
        else $error("Wakeup edge was not reported.");

    property p_release_on_tick;
        $fell(system_reset_ff) |-> $past(sys_tick) && $past(state_ff) == clock_reset_pkg::ST_ALIGN;
    endproperty
    a_release_on_tick: assert property (p_release_on_tick)
        else $error("System reset released off a system tick.");

endmodule // clock_reset_generation
`default_nettype wire

// ---- sim/board_partner.sv ----
`timescale 1ns/100ps
`default_nettype none

// Board reset source and the external local bus device.
module board_partner #(
    parameter int HOLD_CYC = 6
) (
    // Clock.
    input wire logic clk,
    // Requests from the bench.
    input wire logic reset_req,
    input wire logic supply_on,
    input wire logic bus_clk_on,
    // Pin as driven by the block.
    input wire logic pin_out,
    input wire logic pin_oe,
    // Towards the block.
    output logic ext_reset_n,
    output logic supply_ok,
    output logic pin_level
);
    int hold_cnt = HOLD_CYC; // Cycles of reset hold still owed.
    logic bus_clk = 1'b0; // Clock of the bus device.
    // The hold restarts on every request, so a short request still gets a full hold.
    always @(posedge clk) begin
        if (reset_req || !supply_on) begin
            hold_cnt <= HOLD_CYC;
        end else if (hold_cnt != 0) begin
            hold_cnt <= hold_cnt - 1;
        end
    end
    // A 25 MHz clock, only while the bench asks for it.
    // Its edges sit 2 ns off the block clock, so the block never samples it mid-change.
    initial begin
        #2;
        forever #20 bus_clk = bus_clk_on ? ~bus_clk : 1'b0;
    end
    assign ext_reset_n = (hold_cnt == 0) && !reset_req;
    assign supply_ok = supply_on;
    // The pin has a pull-up, so it rests high when nobody drives it.
    assign pin_level = pin_oe ? pin_out : (bus_clk_on ? bus_clk : 1'b1);
endmodule // board_partner

`default_nettype wire

// ---- sim/clock_reset_generation_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module clock_reset_generation_tb;
    logic clk = 1'b0, rst = 1'b1, ext_n, sup_ok, pin_in, pin_out, pin_oe;
    logic [1:0] sel = 2'h3;
    logic s_role = 1'b0, s_time = 1'b1, slow = 1'b0, stop = 1'b0, wake = 1'b0;
    logic rreq = 1'b1, son = 1'b1, bon = 1'b0;
    logic osc, pll, wev, tick, srst, ind;
    clock_reset_pkg::lb_role_t role;
    int err_total = 0, cmp_count = 0, cyc_cnt = 0, n, m;
    // Table: role strap, timing strap, select, bus clock, role, enable.
    logic [7:0] rows [4] = '{8'h73, 8'h84, 8'h14, 8'hC8};
    int exp_t [4] = '{160, 40, 80, 40};

    always #4 clk = ~clk;

    board_partner u_board (.clk(clk), .reset_req(rreq), .supply_on(son), .bus_clk_on(bon),
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_reset_n(ext_n), .supply_ok(sup_ok), .pin_level(pin_in));

    // Short stretch and slow division keep the run brief.
    clock_reset_generation #(.POR_STRETCH_CYC(4), .SLOW_DIV(4)) dut (.clk(clk), .rst(rst),
        .ext_reset_n_in(ext_n), .core_supply_ok(sup_ok), .core_clock_select_pins(sel),
        .bus_role_strap(s_role), .timing_style_strap(s_time), .local_bus_clock_pin_in(pin_in),
        .local_bus_clock_pin_out_ff(pin_out), .local_bus_clock_pin_oe_ff(pin_oe),
        .slow_power_mode(slow), .stop_mode_req(stop), .remote_wakeup_in(wake),
        .osc_enable_ff(osc), .pll_enable_ff(pll), .wakeup_event_ff(wev), .sys_clk_en_ff(tick),
        .system_reset_ff(srst), .cpu_reset_indicator_out_ff(ind), .lb_role_ff(role));

    ////////////////////////////////////////////////////////////////////////////////
    // Inputs move 1 ns after the edge, well clear of sampling.
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // A nonzero tolerance allows for tick phase at the window ends.
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol);
        cmp_count++;
        if (tol == 0 ? g !== e : (g + tol < e || g > e + tol)) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic count_ticks(input int k);
        n = 0;
        m = 0;
        repeat (k) begin
            cyc(1);
            if (tick === 1'b1) n++;
            if (pin_out === 1'b1) m++;
        end
    endtask

    // Bounded wait for the system reset to drop.
    task automatic wait_run;
        for (int i = 0; i < 300 && srst !== 1'b0; i++) cyc(1);
        chk(srst, 0, 0);
        cyc(1);
        chk(ind, 1, 0);
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // A hang counts as a mismatch.
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(3);
        rst = 1'b0;
        rreq = 1'b0;
        wait_run();
        // Each row: straps and select under reset, then role, enable and tick rate.
        foreach (rows[i]) begin
            {s_role, s_time, sel, bon} = rows[i][7:3];
            rst = 1'b1;
            cyc(3);
            rst = 1'b0;
            wait_run();
            cyc(20);
            chk(role, rows[i][2:1], 0);
            chk(pin_oe, rows[i][0], 0);
            count_ticks(200);
            chk(n, exp_t[i], 2);
            chk(m, rows[i][0] ? exp_t[i] : 0, 2);
        end
        // Strap changes while running are ignored.
        {s_role, s_time} = 2'b01;
        cyc(3);
        chk(role, clock_reset_pkg::ROLE_CLOCK_IN, 0);
        // Supply drop resets and resamples the straps.
        bon = 1'b0;
        sel = 2'h3;
        son = 1'b0;
        cyc(2);
        chk(srst, 1, 0);
        cyc(1);
        chk(ind, 0, 0);
        son = 1'b1;
        wait_run();
        chk(role, clock_reset_pkg::ROLE_CLOCK_OUT, 0);
        // Reserved select keeps the full rate.
        sel = 2'h2;
        cyc(20);
        count_ticks(200);
        chk(n, 160, 2);
        slow = 1'b1;
        cyc(30);
        count_ticks(200);
        chk(n, 40, 2);
        slow = 1'b0;
        // External reset pulse.
        rreq = 1'b1;
        cyc(1);
        rreq = 1'b0;
        cyc(1);
        chk(srst, 1, 0);
        wait_run();
        // Stop, then wake on a rising edge.
        stop = 1'b1;
        cyc(1);
        chk({osc, pll}, 0, 0);
        count_ticks(20);
        chk(n, 0, 0);
        stop = 1'b0;
        wake = 1'b1;
        cyc(1);
        chk({osc, pll, wev}, 3'h7, 0);
        cyc(1);
        chk(wev, 0, 0);
        give_verdict();
    end
endmodule // clock_reset_generation_tb

`default_nettype wire
